/* File: rtl/dsd_decoder.sv */
// Data-space decoder with the program-memory read window and bank select.
// Assumes the core drives one request per cycle on the same clock; every
// output is registered, so a route appears one cycle after its request.
//
// Summary of operation
// [R1] Reads at 40h-7Fh come from program memory
// [R2] Window address is base and low six bits
// [R3] Window moves in 64-byte steps up to 0FFFh
// [R4] Base uses bits 5-0, bits 7-6 unused
// [R5] Core never reads or bit-modifies the base
// [R6] Base not reset, software loads it first
// [R7] Software writes shadow copy before base register
// [R8] 00h-3Fh goes to the selected bank page
// [R9] General RAM decoded at 084h-0BFh
// [R10] Core registers X, Y, V, W, accumulator mapped
// [R11] Port, direction, interrupt option registers decoded
// [R12] Converter, timers, watchdog, SPI, EEPROM control decoded
// [R13] Bank codes 01, 02, 10h choose page
// [R14] Bank select not reset by initialisation
// [R15] Writes into the window are dropped
// [R16] Reserved addresses select nothing
`timescale 1ns/1ps

module dsd_decoder (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire dsd_pkg::dsd_req_t req_i,
    output dsd_pkg::dsd_route_t route_o,
    output logic pm_rd_o,
    output logic [dsd_pkg::DSD_PM_ADDR_W-1:0] pm_addr_o,
    output dsd_pkg::dsd_page_t page_o,
    output dsd_pkg::dsd_core_t core_o,
    output dsd_pkg::dsd_periph_t periph_o,
    output logic [2:0] periph_reg_o
);
    import dsd_pkg::*;

    // ****************************************
    // Configuration registers
    // ****************************************
    logic [DSD_WIN_UPPER_W-1:0] rom_window_base;
    logic [7:0] ram_eeprom_bank_select;

    wire [7:0] a = req_i.addr;
    wire acc_any = req_i.rd | req_i.wr;
    wire wr_base = req_i.wr && (a == DSD_ROM_WINDOW_BASE);
    wire wr_bank = req_i.wr && (a == DSD_RAM_EEPROM_BANK_SELECT);

    // No reset on either register: contents stay as software left them
    always_ff @(posedge clk_i) begin
        if (wr_base) begin
            rom_window_base <= req_i.wdata[DSD_WIN_UPPER_W-1:0]; // [R4] [R6]
        end
    end

    always_ff @(posedge clk_i) begin
        if (wr_bank) begin
            ram_eeprom_bank_select <= req_i.wdata; // [R14]
        end
    end

    // ****************************************
    // Region decode
    // ****************************************
    wire in_bank = (a <= DSD_BANK_HI);
    wire in_win = (a >= DSD_WIN_LO) && (a <= DSD_WIN_HI);
    wire in_ram = (a >= DSD_RAM_LO) && (a <= DSD_RAM_HI);
    wire in_cfg = (a == DSD_ROM_WINDOW_BASE) || (a == DSD_RAM_EEPROM_BANK_SELECT);

    dsd_page_t page_dec;
    assign page_dec = (ram_eeprom_bank_select == DSD_BANK_EE0) ? DSD_PAGE_EE0 :
                      (ram_eeprom_bank_select == DSD_BANK_EE1) ? DSD_PAGE_EE1 :
                      (ram_eeprom_bank_select == DSD_BANK_RAM2) ? DSD_PAGE_RAM2 :
                      DSD_PAGE_NONE; // [R13]

    dsd_core_t core_dec;
    assign core_dec = (a == DSD_REG_X) ? DSD_CORE_X :
                      (a == DSD_REG_Y) ? DSD_CORE_Y :
                      (a == DSD_REG_V) ? DSD_CORE_V :
                      (a == DSD_REG_W) ? DSD_CORE_W :
                      (a == DSD_REG_ACC) ? DSD_CORE_ACC :
                      DSD_CORE_NONE; // [R10]

    // ****************************************
    // Peripheral select decode
    // ****************************************
    dsd_periph_t per_dec;
    logic [2:0] per_idx;
    wire [7:0] d_tim = a - DSD_TIM_LO;
    wire [7:0] d_art1 = a - DSD_ART1_LO;
    wire [7:0] d_art2 = a - DSD_ART2_LO + 8'h03;

    always_comb begin
        per_dec = DSD_PER_NONE;
        per_idx = 3'h0;
        if ((a >= DSD_PDATA_LO) && (a <= DSD_PDATA_HI)) begin
            per_dec = DSD_PER_PDATA; // [R11]
            per_idx = {1'b0, a[1:0]};
        end else if ((a >= DSD_PDIR_LO) && (a <= DSD_PDIR_HI)) begin
            per_dec = DSD_PER_PDIR; // [R11]
            per_idx = {1'b0, a[1:0]};
        end else if (a == DSD_INTOPT) begin
            per_dec = DSD_PER_INTOPT; // [R11]
        end else if ((a >= DSD_POPT_LO) && (a <= DSD_POPT_HI)) begin
            per_dec = DSD_PER_POPT; // [R11]
            per_idx = {1'b0, a[1:0]};
        end else if ((a >= DSD_ADC_LO) && (a <= DSD_ADC_HI)) begin
            per_dec = DSD_PER_ADC; // [R12]
            per_idx = {2'h0, a[0]};
        end else if ((a >= DSD_TIM_LO) && (a <= DSD_TIM_HI)) begin
            per_dec = DSD_PER_TIM; // [R12]
            per_idx = d_tim[2:0];
        end else if ((a >= DSD_ART1_LO) && (a <= DSD_ART1_HI)) begin
            per_dec = DSD_PER_ART; // [R12]
            per_idx = d_art1[2:0];
        end else if (a == DSD_WDOG) begin
            per_dec = DSD_PER_WDOG; // [R12]
        end else if ((a >= DSD_ART2_LO) && (a <= DSD_ART2_HI)) begin
            per_dec = DSD_PER_ART; // [R12]
            per_idx = d_art2[2:0];
        end else if (a == DSD_OSC) begin
            per_dec = DSD_PER_OSC; // [R12]
        end else if (a == DSD_MISC) begin
            per_dec = DSD_PER_MISC; // [R12]
        end else if ((a >= DSD_SPI_LO) && (a <= DSD_SPI_HI)) begin
            per_dec = DSD_PER_SPI; // [R12]
            per_idx = {1'b0, a[1:0]};
        end else if (a == DSD_EECTL) begin
            per_dec = DSD_PER_EECTL; // [R12]
        end
    end

    // ****************************************
    // Target selection
    // ****************************************
    dsd_target_t tgt_dec;
    assign tgt_dec = !acc_any ? DSD_TGT_NONE :
                     (in_bank && page_dec != DSD_PAGE_NONE) ? DSD_TGT_BANK : // [R8]
                     (in_win && req_i.rd) ? DSD_TGT_WINDOW : // [R1] [R15]
                     (core_dec != DSD_CORE_NONE) ? DSD_TGT_CORE :
                     in_ram ? DSD_TGT_RAM : // [R9]
                     (per_dec != DSD_PER_NONE) ? DSD_TGT_PERIPH :
                     (in_cfg && req_i.wr) ? DSD_TGT_CFG :
                     DSD_TGT_NONE; // [R16]

    wire [7:0] ram_off = a - DSD_RAM_LO;
    wire sel = (tgt_dec != DSD_TGT_NONE);

    dsd_route_t next_route;
    assign next_route.tgt = tgt_dec;
    assign next_route.rd = sel & req_i.rd;
    assign next_route.wr = sel & req_i.wr & (tgt_dec != DSD_TGT_WINDOW); // [R15] [R16]
    assign next_route.off = (tgt_dec == DSD_TGT_RAM) ? ram_off[DSD_OFF_W-1:0] : a[DSD_OFF_W-1:0];
    assign next_route.wdata = req_i.wdata;

    wire next_pm_rd = (tgt_dec == DSD_TGT_WINDOW);
    wire [DSD_PM_ADDR_W-1:0] next_pm_addr = {rom_window_base, a[DSD_OFF_W-1:0]}; // [R2] [R3]

    // ****************************************
    // Output registers
    // ****************************************
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            route_o <= '0;
            pm_rd_o <= 1'b0;
            pm_addr_o <= '0;
            page_o <= DSD_PAGE_NONE;
            core_o <= DSD_CORE_NONE;
            periph_o <= DSD_PER_NONE;
            periph_reg_o <= 3'h0;
        end else begin
            route_o <= next_route;
            pm_rd_o <= next_pm_rd; // [R1]
            pm_addr_o <= next_pm_rd ? next_pm_addr : pm_addr_o;
            page_o <= (tgt_dec == DSD_TGT_BANK) ? page_dec : DSD_PAGE_NONE; // [R8] [R13]
            core_o <= (tgt_dec == DSD_TGT_CORE) ? core_dec : DSD_CORE_NONE;
            periph_o <= (tgt_dec == DSD_TGT_PERIPH) ? per_dec : DSD_PER_NONE;
            periph_reg_o <= (tgt_dec == DSD_TGT_PERIPH) ? per_idx : 3'h0;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_window_read: assert property (req_i.rd && a >= DSD_WIN_LO && a <= DSD_WIN_HI // [R1]
        |=> pm_rd_o && route_o.tgt == DSD_TGT_WINDOW && route_o.rd)
        else $error("window read not routed to program memory");

    a_window_addr: assert property (wr_base ##1 (req_i.rd && in_win && !wr_base) // [R2]
        |=> pm_addr_o == {$past(req_i.wdata[5:0], 2), $past(req_i.addr[5:0])})
        else $error("window address not formed from base and offset");

    a_base_upper: assert property (wr_base && req_i.wdata[7:6] != 2'h0 ##1 (req_i.rd && in_win) // [R4]
        |=> pm_addr_o[11:6] == $past(req_i.wdata[5:0], 2))
        else $error("base upper bits leak into window address");

    a_window_nowr: assert property (req_i.wr && in_win // [R15]
        |=> !route_o.wr && pm_rd_o == $past(req_i.rd) && (route_o.tgt == DSD_TGT_WINDOW) == $past(req_i.rd))
        else $error("write to window area not dropped");

    a_bank_page: assert property (wr_bank && req_i.wdata == DSD_BANK_EE1 ##1 (acc_any && in_bank && !wr_bank) // [R13]
        |=> route_o.tgt == DSD_TGT_BANK && page_o == DSD_PAGE_EE1)
        else $error("bank page 1 not selected");

    a_bank_none: assert property (wr_bank && req_i.wdata == 8'h08 ##1 (acc_any && in_bank && !wr_bank) // [R13]
        |=> route_o.tgt == DSD_TGT_NONE && page_o == DSD_PAGE_NONE)
        else $error("reserved bank code selected a page");

    a_ram_off: assert property (acc_any && in_ram // [R9]
        |=> route_o.tgt == DSD_TGT_RAM && route_o.off == 6'(($past(req_i.addr) - DSD_RAM_LO)))
        else $error("ram offset wrong");

    a_core_acc: assert property (acc_any && a == DSD_REG_ACC // [R10]
        |=> route_o.tgt == DSD_TGT_CORE && core_o == DSD_CORE_ACC)
        else $error("accumulator not selected");

    a_art_split: assert property (acc_any && a == DSD_ART2_LO // [R12]
        |=> periph_o == DSD_PER_ART && periph_reg_o == 3'h3)
        else $error("second timer range index wrong");

    a_port_opt: assert property (acc_any && a == DSD_POPT_HI // [R11]
        |=> periph_o == DSD_PER_POPT && periph_reg_o == 3'h2)
        else $error("port option select wrong");

    a_reserved: assert property (acc_any && (a == 8'hC3 || a == 8'hE9 || a == 8'hFE) // [R16]
        |=> route_o.tgt == DSD_TGT_NONE && !route_o.rd && !route_o.wr)
        else $error("reserved address selected a target");

    a_cfg_noread: assert property (req_i.rd && !req_i.wr && in_cfg // [R16]
        |=> route_o.tgt == DSD_TGT_NONE)
        else $error("write-only register answered a read");

    c_window_read: cover property (wr_base ##[1:4] (req_i.rd && in_win));
    c_bank_ram2: cover property (wr_bank && req_i.wdata == DSD_BANK_RAM2 ##1 (req_i.wr && in_bank));
    c_periph_eectl: cover property (req_i.wr && a == DSD_EECTL);
    c_window_write: cover property (req_i.wr && in_win);

endmodule

/* File: rtl/dsd_pkg.sv */
// Package for the data-space decoder: address map, field layouts and the
// enumerations and carriers shared by the decoder and its surroundings.
// Assumes an 8-bit data space and a 12-bit program memory address.
package dsd_pkg;

    // ****************************************
    // Address map
    // ****************************************
    localparam logic [7:0] DSD_BANK_LO = 8'h00;
    localparam logic [7:0] DSD_BANK_HI = 8'h3F;
    localparam logic [7:0] DSD_WIN_LO = 8'h40;
    localparam logic [7:0] DSD_WIN_HI = 8'h7F;
    localparam logic [7:0] DSD_REG_X = 8'h80;
    localparam logic [7:0] DSD_REG_Y = 8'h81;
    localparam logic [7:0] DSD_REG_V = 8'h82;
    localparam logic [7:0] DSD_REG_W = 8'h83;
    localparam logic [7:0] DSD_RAM_LO = 8'h84;
    localparam logic [7:0] DSD_RAM_HI = 8'hBF;
    localparam logic [7:0] DSD_PDATA_LO = 8'hC0;
    localparam logic [7:0] DSD_PDATA_HI = 8'hC2;
    localparam logic [7:0] DSD_PDIR_LO = 8'hC4;
    localparam logic [7:0] DSD_PDIR_HI = 8'hC6;
    localparam logic [7:0] DSD_INTOPT = 8'hC8;
    localparam logic [7:0] DSD_ROM_WINDOW_BASE = 8'hC9;
    localparam logic [7:0] DSD_POPT_LO = 8'hCC;
    localparam logic [7:0] DSD_POPT_HI = 8'hCE;
    localparam logic [7:0] DSD_ADC_LO = 8'hD0;
    localparam logic [7:0] DSD_ADC_HI = 8'hD1;
    localparam logic [7:0] DSD_TIM_LO = 8'hD2;
    localparam logic [7:0] DSD_TIM_HI = 8'hD4;
    localparam logic [7:0] DSD_ART1_LO = 8'hD5;
    localparam logic [7:0] DSD_ART1_HI = 8'hD7;
    localparam logic [7:0] DSD_WDOG = 8'hD8;
    localparam logic [7:0] DSD_ART2_LO = 8'hD9;
    localparam logic [7:0] DSD_ART2_HI = 8'hDB;
    localparam logic [7:0] DSD_OSC = 8'hDC;
    localparam logic [7:0] DSD_MISC = 8'hDD;
    localparam logic [7:0] DSD_SPI_LO = 8'hE0;
    localparam logic [7:0] DSD_SPI_HI = 8'hE2;
    localparam logic [7:0] DSD_RAM_EEPROM_BANK_SELECT = 8'hE8;
    localparam logic [7:0] DSD_EECTL = 8'hEA;
    localparam logic [7:0] DSD_REG_ACC = 8'hFF;

    // ****************************************
    // Field layouts and codes
    // ****************************************
    localparam int DSD_WIN_UPPER_W = 6;
    localparam int DSD_OFF_W = 6;
    localparam int DSD_PM_ADDR_W = 12;
    localparam logic [7:0] DSD_BANK_EE0 = 8'h01;
    localparam logic [7:0] DSD_BANK_EE1 = 8'h02;
    localparam logic [7:0] DSD_BANK_RAM2 = 8'h10;

    // ****************************************
    // Enumerations and carriers
    // ****************************************
    typedef enum logic [2:0] {
        DSD_TGT_NONE, DSD_TGT_BANK, DSD_TGT_WINDOW, DSD_TGT_CORE,
        DSD_TGT_RAM, DSD_TGT_PERIPH, DSD_TGT_CFG
    } dsd_target_t;

    typedef enum logic [1:0] {
        DSD_PAGE_NONE, DSD_PAGE_EE0, DSD_PAGE_EE1, DSD_PAGE_RAM2
    } dsd_page_t;

    typedef enum logic [2:0] {
        DSD_CORE_NONE, DSD_CORE_X, DSD_CORE_Y, DSD_CORE_V, DSD_CORE_W, DSD_CORE_ACC
    } dsd_core_t;

    typedef enum logic [3:0] {
        DSD_PER_NONE, DSD_PER_PDATA, DSD_PER_PDIR, DSD_PER_INTOPT, DSD_PER_POPT,
        DSD_PER_ADC, DSD_PER_TIM, DSD_PER_ART, DSD_PER_WDOG, DSD_PER_OSC,
        DSD_PER_MISC, DSD_PER_SPI, DSD_PER_EECTL
    } dsd_periph_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dsd_req_t;

    typedef struct packed {
        dsd_target_t tgt;
        logic rd;
        logic wr;
        logic [DSD_OFF_W-1:0] off;
        logic [7:0] wdata;
    } dsd_route_t;

endpackage

/* File: test/data_space_decoder_rom_window_test.sv */
// Self-checking bench for the data-space decoder.
// Assumes the core model drives requests and outputs are one cycle late.
`timescale 1ns/1ps

module data_space_decoder_rom_window_test;
    import dsd_pkg::*;

    // ****************************************
    // Bench signals, tables and tasks
    // ****************************************
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    dsd_req_t req;
    dsd_route_t route;
    logic pm_rd;
    logic [DSD_PM_ADDR_W-1:0] pm_addr;
    dsd_page_t page;
    dsd_core_t core_sel;
    dsd_periph_t periph;
    logic [2:0] periph_reg;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [15:0] per_tab [21] = '{16'hC010, 16'hC212, 16'hC420, 16'hC622, 16'hC830, 16'hCC40, 16'hCE42,
        16'hD050, 16'hD151, 16'hD260, 16'hD462, 16'hD570, 16'hD772, 16'hD880, 16'hD973, 16'hDB75,
        16'hDC90, 16'hDDA0, 16'hE0B0, 16'hE2B2, 16'hEAC0};
    logic [7:0] rsv_tab [13] = '{8'hC3, 8'hC7, 8'hC9, 8'hCA, 8'hCB, 8'hCF, 8'hDE, 8'hDF, 8'hE3, 8'hE7,
        8'hE8, 8'hE9, 8'hFE};
    logic [7:0] codes [5] = '{8'h01, 8'h02, 8'h10, 8'h00, 8'h08};
    dsd_page_t pages [5] = '{DSD_PAGE_EE0, DSD_PAGE_EE1, DSD_PAGE_RAM2, DSD_PAGE_NONE, DSD_PAGE_NONE};
    logic [7:0] core_adr [5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF};
    dsd_core_t cores [5] = '{DSD_CORE_X, DSD_CORE_Y, DSD_CORE_V, DSD_CORE_W, DSD_CORE_ACC};

    dsd_core_model u_core (.clk_i(clk_i), .req_o(req));

    dsd_decoder dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .route_o(route), .pm_rd_o(pm_rd),
        .pm_addr_o(pm_addr), .page_o(page), .core_o(core_sel), .periph_o(periph), .periph_reg_o(periph_reg));

    always #2.5 clk_i = ~clk_i;

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            test_done();
        end
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic chk_route(input dsd_target_t tgt, input logic rd, input logic wr);
        chk("target", route.tgt, tgt);
        chk("read strobe", route.rd, rd);
        chk("write strobe", route.wr, wr);
    endtask

    task automatic chk_sel(input dsd_page_t pg, input dsd_core_t cr, input dsd_periph_t pe, input logic [2:0] ix);
        chk("page", page, pg);
        chk("core select", core_sel, cr);
        chk("peripheral", periph, pe);
        chk("peripheral index", periph_reg, ix);
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge clk_i);
        chk_route(DSD_TGT_NONE, 1'b0, 1'b0);
        @(negedge clk_i);
        rst_i = 1'b0;
        u_core.set_base(8'hC5);
        chk_route(DSD_TGT_CFG, 1'b0, 1'b1);
        u_core.issue(1'b1, 1'b0, 8'h41, 8'h00);
        chk_route(DSD_TGT_WINDOW, 1'b1, 1'b0);
        chk("window read", pm_rd, 1'b1);
        chk("window address", pm_addr, 12'h141);
        chk("offset", route.off, 6'h01);
        u_core.issue(1'b0, 1'b1, 8'h50, 8'hAA);
        chk_route(DSD_TGT_NONE, 1'b0, 1'b0);
        chk("window read", pm_rd, 1'b0);
        chk("window address", pm_addr, 12'h141);
        u_core.issue(1'b1, 1'b1, 8'h42, 8'h33);
        chk_route(DSD_TGT_WINDOW, 1'b1, 1'b0);
        chk("window address", pm_addr, 12'h142);
        u_core.set_base(8'h3F);
        u_core.issue(1'b1, 1'b0, 8'h7F, 8'h00);
        chk("window address", pm_addr, 12'hFFF);
        u_core.set_base(8'h00);
        u_core.issue(1'b1, 1'b0, 8'h40, 8'h00);
        chk("window address", pm_addr, 12'h000);
        foreach (rsv_tab[i]) begin
            u_core.issue(1'b1, 1'b0, rsv_tab[i], 8'h00);
            chk_route(DSD_TGT_NONE, 1'b0, 1'b0);
        end
        u_core.issue(1'b0, 1'b1, 8'hC3, 8'h5A);
        chk_route(DSD_TGT_NONE, 1'b0, 1'b0);
        foreach (core_adr[i]) begin
            u_core.issue(1'b1, 1'b0, core_adr[i], 8'h00);
            chk_route(DSD_TGT_CORE, 1'b1, 1'b0);
            chk_sel(DSD_PAGE_NONE, cores[i], DSD_PER_NONE, 3'h0);
        end
        u_core.issue(1'b0, 1'b1, 8'h84, 8'h11);
        chk_route(DSD_TGT_RAM, 1'b0, 1'b1);
        chk("offset", route.off, 6'h00);
        chk("write data", route.wdata, 8'h11);
        u_core.issue(1'b1, 1'b0, 8'hBF, 8'h00);
        chk("offset", route.off, 6'h3B);
        foreach (codes[i]) begin
            u_core.issue(1'b0, 1'b1, DSD_RAM_EEPROM_BANK_SELECT, codes[i]);
            u_core.issue(1'b1, 1'b0, 8'h3F, 8'h00);
            chk("page", page, pages[i]);
            chk("target", route.tgt, (pages[i] == DSD_PAGE_NONE) ? DSD_TGT_NONE : DSD_TGT_BANK);
        end
        foreach (per_tab[i]) begin
            u_core.issue(1'b1, 1'b0, per_tab[i][15:8], 8'h00);
            chk_route(DSD_TGT_PERIPH, 1'b1, 1'b0);
            chk_sel(DSD_PAGE_NONE, DSD_CORE_NONE, dsd_periph_t'(per_tab[i][7:4]), per_tab[i][2:0]);
        end
        u_core.issue(1'b0, 1'b1, DSD_RAM_EEPROM_BANK_SELECT, 8'h10);
        u_core.set_base(8'h02);
        u_core.release_bus();
        rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        chk("window read", pm_rd, 1'b0);
        rst_i = 1'b0;
        u_core.issue(1'b1, 1'b0, 8'h05, 8'h00);
        chk("page", page, DSD_PAGE_RAM2);
        chk("offset", route.off, 6'h05);
        u_core.issue(1'b1, 1'b0, 8'h45, 8'h00);
        chk("window address", pm_addr, 12'h085);
        u_core.release_bus();
        test_done();
    end
endmodule

/* File: test/dsd_core_model.sv */
// Behavioural model of the processor core that issues data-space requests.
// Assumes the bench calls its tasks one after another on the decoder clock.
`timescale 1ns/1ps

module dsd_core_model (
    input wire logic clk_i,
    output dsd_pkg::dsd_req_t req_o
);
    import dsd_pkg::*;

    // ****************************************
    // Request driving
    // ****************************************
    initial req_o = '0;

    // One request, driven at the falling edge and held over the rising edge
    task automatic issue(input logic rd, input logic wr, input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_i);
        req_o.rd = rd;
        req_o.wr = wr;
        req_o.addr = addr;
        req_o.wdata = data;
        @(posedge clk_i);
        #1;
    endtask

    // Whole-byte writes only, shadow copy first, base loaded before any window read
    task automatic set_base(input logic [7:0] val);
        issue(1'b0, 1'b1, DSD_RAM_LO, val);
        issue(1'b0, 1'b1, DSD_ROM_WINDOW_BASE, val);
    endtask

    // Released bus shows no stale address or data
    task automatic release_bus();
        @(negedge clk_i);
        req_o.rd = 1'b0;
        req_o.wr = 1'b0;
        req_o.addr = ~req_o.addr;
        req_o.wdata = ~req_o.wdata;
    endtask
endmodule
